/* File: pkg/sacl_pkg.sv */
// constants, types and field layout of the converter control block
// assumes a 10 MHz bus clock and a 32-bit apb master with byte addresses
// ============================================================
`default_nettype none
package sacl_pkg;
	// ============================================================
	// register byte addresses
	localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00; // status and control
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04; // result high
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h08; // result low
	localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h0C; // clock and mode
	// ============================================================
	// field positions
	localparam int SCR_CONV_COMPLETE_FLAG_BIT = 7; // completion flag
	localparam int SCR_IRQ_ENABLE_BIT_BIT = 6; // interrupt enable
	localparam int SCR_CONTINUOUS_CONV_BIT_BIT = 5; // continuous bit
	localparam int CLK_DIV_LSB = 5; // divider field 7:5
	localparam int CLK_SRC_BIT = 4; // clock source
	localparam int CLK_MODE_LSB = 2; // justification 3:2
	// ============================================================
	// reset values and codes
	localparam logic [4:0] CH_OFF = 5'h1F; // power-off code, reset value
	localparam logic [4:0] CH_PORT_LAST = 5'h06; // last port line code
	localparam logic [1:0] MODE_TRUNC8 = 2'h0; // 8-bit truncation
	localparam logic [1:0] MODE_RIGHT = 2'h1; // right justified, reset value
	localparam logic [1:0] MODE_LEFT = 2'h2; // left justified
	localparam logic [1:0] MODE_SIGNED = 2'h3; // left justified signed
	localparam logic [2:0] DIV_RST = 3'h0; // divide by one
	localparam logic SRC_RST = 1'b0; // external reference clock
	// ============================================================
	// conversion timing in converter clock cycles
	localparam logic [4:0] SAMPLE_STEPS = 5'h06; // steps spent sampling
	localparam logic [4:0] LAST_STEP = 5'h0F; // sixteenth step
	localparam logic [3:0] DIV_MAX_M1 = 4'hF; // divide by sixteen, minus one
	// ============================================================
	// conversion sequencer
	typedef enum logic [0:0] {S_IDLE, S_CONV} sacl_state_e;
endpackage
`default_nettype wire

/* File: hw/sacl_top.sv */
// converter control: apb registers, clock prescaler, sar sequencer, formatting
// assumes an analog comparator outside that answers against the trial code
// and port logic outside that honours the override mask
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module sacl_top (
	input wire logic CLOCK_IN, // bus clock, 10 MHz
	input wire logic RST_B_IN, // async reset, active low
	input wire logic PSEL_IN, // apb select
	input wire logic PENABLE_IN, // apb enable
	input wire logic PWRITE_IN, // apb direction
	input wire logic [7:0] PADDR_IN, // apb byte address
	input wire logic [31:0] PWDATA_IN, // apb write data
	input wire logic EXT_REF_CLK_IN, // external reference clock, async
	input wire logic COMP_IN, // comparator: input above trial code
	input wire logic STOP_IN, // processor in stop mode
	output logic [31:0] PRDATA_OUT, // apb read data
	output logic PREADY_OUT, // apb ready
	output logic PSLVERR_OUT, // apb error on unmapped address
	output logic IRQ_OUT, // interrupt request, level
	output logic ADC_POWER_ON_OUT, // analog part powered
	output logic [4:0] CHANNEL_SEL_OUT, // multiplexer select
	output logic [9:0] DAC_CODE_OUT, // sar trial code
	output logic SAMPLE_OUT, // input sampling window
	output logic [6:0] PORT_OVERRIDE_OUT // port line taken by converter
);
	// ============================================================
	// state
	typedef struct packed {
		sacl_pkg::sacl_state_e st; // sequencer state
		logic [4:0] step; // converter cycle in conversion
		logic [9:0] sar; // approximation register
		logic conv_complete_flag; // completion flag
		logic irq_enable_bit; // interrupt enable
		logic continuous_conv_bit; // continuous bit
		logic [4:0] ch; // channel select field
		logic [2:0] div; // clock divider field
		logic src; // clock source select
		logic [1:0] mode; // justification field
		logic [7:0] res_h; // result high
		logic [7:0] res_l; // result low
		logic lock; // low result frozen
		logic irq_pend; // pending request
		logic first_done; // a conversion finished since start
		logic [3:0] pcnt; // prescaler count
		logic ext_s1; // reference clock sync stage one
		logic ext_s2; // reference clock sync stage two
		logic ext_s3; // edge detect history
		logic cmp_s1; // comparator sync stage one
		logic cmp_s2; // comparator sync stage two
		logic stop_d; // stop level last cycle
		logic [7:0] prdata; // read data
		logic pready; // ready
		logic pslverr; // error
		logic irq; // interrupt output
		logic pwr; // power output
		logic samp; // sampling output
		logic [6:0] pmask; // port override output
	} sacl_regs_s;

	sacl_regs_s r_reg; // registered state
	sacl_regs_s r_next; // next state
	logic acc_done; // apb transfer completes this edge
	logic wr_en; // completing write
	logic rd_en; // completing read
	logic in_tick; // converter input clock tick
	logic [3:0] div_m1; // divide ratio minus one
	logic adc_tick; // converter clock enable
	logic conv_done; // conversion ends this edge
	logic [9:0] sar_val; // approximation after this step
	logic [9:0] res_fmt; // result with sign bit applied
	logic hold_low; // high read in flight or done
	logic restart; // begin a fresh conversion

	// ============================================================
	// next state
	always_comb begin
		r_next = r_reg;
		// two-flop synchronisers, third flop for edge
		r_next.ext_s1 = EXT_REF_CLK_IN;
		r_next.ext_s2 = r_reg.ext_s1;
		r_next.ext_s3 = r_reg.ext_s2;
		r_next.cmp_s1 = COMP_IN;
		r_next.cmp_s2 = r_reg.cmp_s1;
		r_next.stop_d = STOP_IN;

		// bus decode: one wait state, side effects at the ready edge
		acc_done = PSEL_IN & PENABLE_IN & r_reg.pready;
		wr_en = acc_done & PWRITE_IN;
		rd_en = acc_done & ~PWRITE_IN;

		// input clock and prescaler
		in_tick = r_reg.src ? 1'b1 : (r_reg.ext_s2 & ~r_reg.ext_s3);
		if (r_reg.div[2]) begin
			div_m1 = sacl_pkg::DIV_MAX_M1;
		end else begin
			div_m1 = 4'((5'h01 << r_reg.div[1:0]) - 5'h01);
		end
		adc_tick = in_tick && (r_reg.pcnt >= div_m1);
		// prescaler count, cleared on every start so that a
		// conversion never runs longer than sixteen full periods;
		// the reference clock edge alignment can cut the first one short
		if (in_tick) begin
			r_next.pcnt = adc_tick ? 4'h0 : r_reg.pcnt + 4'h1;
		end

		// successive approximation steps
		conv_done = 1'b0;
		sar_val = r_reg.sar;
		if (r_reg.st == sacl_pkg::S_CONV && adc_tick) begin
			if (r_reg.step == sacl_pkg::SAMPLE_STEPS - 5'h01) begin
				sar_val = 10'h200; // first trial, top bit
			end else if (r_reg.step >= sacl_pkg::SAMPLE_STEPS) begin
				// drop the trial bit if input below trial
				if (!r_reg.cmp_s2) begin
					sar_val[4'(sacl_pkg::LAST_STEP - r_reg.step)] = 1'b0;
				end
				if (r_reg.step != sacl_pkg::LAST_STEP) begin
					sar_val[4'(sacl_pkg::LAST_STEP - r_reg.step - 5'h01)] = 1'b1;
				end
			end
			r_next.sar = sar_val;
			r_next.step = r_reg.step + 5'h01;
			conv_done = (r_reg.step == sacl_pkg::LAST_STEP);
		end

		// ========================================================
		// bus writes and read side effects (clears first)
		hold_low = r_reg.lock | (PSEL_IN & ~PWRITE_IN & (PADDR_IN == sacl_pkg::ADDR_RESULT_HIGH));
		restart = 1'b0;
		if (wr_en && PADDR_IN == sacl_pkg::ADDR_STATUS_CONTROL) begin
			r_next.irq_enable_bit = PWDATA_IN[sacl_pkg::SCR_IRQ_ENABLE_BIT_BIT];
			r_next.continuous_conv_bit = PWDATA_IN[sacl_pkg::SCR_CONTINUOUS_CONV_BIT_BIT];
			r_next.ch = PWDATA_IN[4:0];
			// flag writable only with interrupts on
			r_next.conv_complete_flag = PWDATA_IN[sacl_pkg::SCR_IRQ_ENABLE_BIT_BIT] & PWDATA_IN[sacl_pkg::SCR_CONV_COMPLETE_FLAG_BIT];
			r_next.irq_pend = 1'b0;
			restart = 1'b1;
		end else if (wr_en && PADDR_IN == sacl_pkg::ADDR_CLOCK_CONFIG) begin
			r_next.div = PWDATA_IN[sacl_pkg::CLK_DIV_LSB +: 3];
			r_next.src = PWDATA_IN[sacl_pkg::CLK_SRC_BIT];
			r_next.mode = PWDATA_IN[sacl_pkg::CLK_MODE_LSB +: 2];
		end else if (rd_en && PADDR_IN == sacl_pkg::ADDR_RESULT_HIGH) begin
			r_next.lock = (r_reg.mode != sacl_pkg::MODE_TRUNC8);
			r_next.irq_pend = 1'b0;
			if (!r_reg.irq_enable_bit) begin
				r_next.conv_complete_flag = 1'b0;
			end
		end else if (rd_en && PADDR_IN == sacl_pkg::ADDR_RESULT_LOW) begin
			r_next.lock = 1'b0;
			r_next.irq_pend = 1'b0;
			if (!r_reg.irq_enable_bit) begin
				r_next.conv_complete_flag = 1'b0;
			end
		end

		// ========================================================
		// conversion end: sets win over the clears above
		res_fmt = sar_val;
		if (r_reg.mode == sacl_pkg::MODE_SIGNED) begin
			res_fmt[9] = ~sar_val[9];
		end
		if (conv_done) begin
			r_next.first_done = 1'b1;
			if (r_reg.irq_enable_bit) begin
				r_next.irq_pend = 1'b1;
			end else if (!r_reg.continuous_conv_bit || !r_reg.first_done) begin
				r_next.conv_complete_flag = 1'b1;
			end
			if (r_reg.mode == sacl_pkg::MODE_TRUNC8) begin
				r_next.res_l = res_fmt[9:2];
				r_next.res_h = 8'h00;
			end else if (!hold_low) begin
				if (r_reg.mode == sacl_pkg::MODE_RIGHT) begin
					r_next.res_h = {6'h00, res_fmt[9:8]};
					r_next.res_l = res_fmt[7:0];
				end else begin
					r_next.res_h = res_fmt[9:2];
					r_next.res_l = {res_fmt[1:0], 6'h00};
				end
			end
			// back to back in continuous mode, else one shot
			if (r_reg.continuous_conv_bit) begin
				r_next.step = 5'h00;
				r_next.sar = 10'h000;
			end else begin
				r_next.st = sacl_pkg::S_IDLE;
			end
		end

		// ========================================================
		// start, stop and power
		if (r_reg.stop_d && !STOP_IN) begin
			restart = 1'b1;
		end
		if (restart) begin
			r_next.st = sacl_pkg::S_CONV;
			r_next.pcnt = 4'h0;
			r_next.step = 5'h00;
			r_next.sar = 10'h000;
			r_next.first_done = 1'b0;
		end
		if (STOP_IN || r_next.ch == sacl_pkg::CH_OFF) begin
			r_next.st = sacl_pkg::S_IDLE;
			r_next.step = 5'h00;
		end
		r_next.pwr = (r_next.ch != sacl_pkg::CH_OFF) & ~STOP_IN;
		r_next.samp = (r_next.st == sacl_pkg::S_CONV) && (r_next.step < sacl_pkg::SAMPLE_STEPS);
		for (int i = 0; i < 7; i++) begin
			// port logic masks this line while it is the input
			r_next.pmask[i] = r_next.pwr && (r_next.ch == 5'(i));
		end
		// request only while flag is zero in interrupt mode
		r_next.irq = r_next.irq_pend & r_next.irq_enable_bit & ~r_next.conv_complete_flag;

		// ========================================================
		// apb read data, captured the cycle before ready
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;
		if (PSEL_IN && PENABLE_IN && !r_reg.pready) begin
			r_next.pready = 1'b1;
			r_next.prdata = 8'h00;
			if (PADDR_IN == sacl_pkg::ADDR_STATUS_CONTROL) begin
				r_next.prdata = {r_reg.conv_complete_flag, r_reg.irq_enable_bit, r_reg.continuous_conv_bit, r_reg.ch};
			end else if (PADDR_IN == sacl_pkg::ADDR_RESULT_HIGH) begin
				r_next.prdata = r_reg.res_h;
			end else if (PADDR_IN == sacl_pkg::ADDR_RESULT_LOW) begin
				r_next.prdata = r_reg.res_l;
			end else if (PADDR_IN == sacl_pkg::ADDR_CLOCK_CONFIG) begin
				r_next.prdata = {r_reg.div, r_reg.src, r_reg.mode, 2'h0};
			end else begin
				r_next.pslverr = 1'b1; // unmapped: error, data zero
			end
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			r_reg <= '0;
			r_reg.st <= sacl_pkg::S_IDLE;
			r_reg.ch <= sacl_pkg::CH_OFF;
			r_reg.mode <= sacl_pkg::MODE_RIGHT;
			r_reg.div <= sacl_pkg::DIV_RST;
			r_reg.src <= sacl_pkg::SRC_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// ============================================================
	// outputs, all from flops
	assign PRDATA_OUT = {24'h000000, r_reg.prdata};
	assign PREADY_OUT = r_reg.pready;
	assign PSLVERR_OUT = r_reg.pslverr;
	assign IRQ_OUT = r_reg.irq;
	assign ADC_POWER_ON_OUT = r_reg.pwr;
	assign CHANNEL_SEL_OUT = r_reg.ch;
	assign DAC_CODE_OUT = r_reg.sar;
	assign SAMPLE_OUT = r_reg.samp;
	assign PORT_OVERRIDE_OUT = r_reg.pmask;
endmodule
`default_nettype wire

/* File: sim/sacl_analog_model.sv */
// analog side model: ideal comparator against a held input level
// assumes the bench holds the level steady while a conversion runs
`timescale 1ns/100ps
`default_nettype none
module sacl_analog_model (
	input wire logic [9:0] dac_in, // trial code
	input wire logic [9:0] level_in, // input level
	output logic comp_out // high when level at or above trial
);
	// ============================================================
	// no offset, so a good sequencer returns the level itself
	assign comp_out = (level_in >= dac_in);
endmodule
`default_nettype wire

/* File: sim/sacl_assertions.sv */
// port checks for the converter control block
// assumes bind into sacl_top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module sacl_checker (
	input wire logic CLOCK_IN, // clock
	input wire logic RST_B_IN, // reset
	input wire logic PSEL_IN, // select
	input wire logic PENABLE_IN, // enable
	input wire logic PWRITE_IN, // direction
	input wire logic [7:0] PADDR_IN, // address
	input wire logic STOP_IN, // stop mode
	input wire logic PREADY_OUT, // ready
	input wire logic PSLVERR_OUT, // error
	input wire logic IRQ_OUT, // request
	input wire logic ADC_POWER_ON_OUT, // power
	input wire logic [4:0] CHANNEL_SEL_OUT, // channel
	input wire logic SAMPLE_OUT, // sampling
	input wire logic [6:0] PORT_OVERRIDE_OUT // override
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_B_IN);
	logic acc; // transfer taken
	logic drop; // status write or result read
	assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
	assign drop = acc && (PWRITE_IN ? PADDR_IN == 8'h00 : PADDR_IN inside {8'h04, 8'h08});
	// ============================================================
	// bus answer
	ready_one_wait_a: // one wait state
		assert property (PSEL_IN && !PENABLE_IN |=> !PREADY_OUT ##1 PREADY_OUT)
		else $error("ready late or early");
	ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held");
	slverr_map_a: assert property (acc |-> PSLVERR_OUT == !(PADDR_IN inside {8'h00, 8'h04, 8'h08, 8'h0C}))
		else $error("error flag wrong");
	// ============================================================
	// conversion control
	power_off_a: assert property (CHANNEL_SEL_OUT == 5'h1F && $stable(CHANNEL_SEL_OUT) |-> !ADC_POWER_ON_OUT)
		else $error("powered with off code");
	stop_power_a: assert property (STOP_IN |=> !ADC_POWER_ON_OUT)
		else $error("powered in stop");
	stop_sample_a: assert property (STOP_IN [*2] |-> !SAMPLE_OUT)
		else $error("sampling in stop");
	override_sel_a: assert property (PORT_OVERRIDE_OUT != 7'h00 && $stable(CHANNEL_SEL_OUT) |-> PORT_OVERRIDE_OUT == 7'h01 << CHANNEL_SEL_OUT)
		else $error("override not the selected line");
	req_drop_a: assert property (drop |=> ##1 !IRQ_OUT)
		else $error("request not dropped");
	cover property ($rose(IRQ_OUT));
	cover property (acc && PSLVERR_OUT);
	cover property ($fell(SAMPLE_OUT));
endmodule
bind sacl_top sacl_checker u_chk (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .STOP_IN(STOP_IN),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
	.ADC_POWER_ON_OUT(ADC_POWER_ON_OUT), .CHANNEL_SEL_OUT(CHANNEL_SEL_OUT),
	.SAMPLE_OUT(SAMPLE_OUT), .PORT_OVERRIDE_OUT(PORT_OVERRIDE_OUT));
`default_nettype wire

/* File: sim/tb_sar_adc_control_logic.sv */
// self-checking bench for the converter control block
// assumes design, analog model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_control_logic;
	// ============================================================
	// signals
	logic clk = 1'b0, rst_b = 1'b0; // clock, reset
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0; // apb request
	logic stop = 1'b0, ext_clk = 1'b0, ext_run = 1'b0; // stop, reference clock
	logic [7:0] paddr = 8'h00; // address
	logic [31:0] pwdata = 32'h0, prdata, rd; // write, read, last read
	logic [9:0] level = 10'h000, dac; // level, trial code
	logic [15:0] e; // expected result pair
	logic pready, pslverr, irq, pwr_on, sample, comp, err; // outputs
	logic [4:0] ch_sel; // channel
	logic [6:0] ovr; // override
	logic [2:0] dv [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7, 3'h2}; // divider codes, /4 last
	int error_cnt = 0, samples_checked = 0, n, c, r; // counts
	always #50 clk = ~clk;
	// reference runs only on request, slow enough for the comparator
	always @(posedge clk) if (ext_run) ext_clk <= ~ext_clk;
	sacl_top u_dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .EXT_REF_CLK_IN(ext_clk),
		.COMP_IN(comp), .STOP_IN(stop), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .ADC_POWER_ON_OUT(pwr_on),
		.CHANNEL_SEL_OUT(ch_sel), .DAC_CODE_OUT(dac), .SAMPLE_OUT(sample),
		.PORT_OVERRIDE_OUT(ovr));
	sacl_analog_model u_ana (.dac_in(dac), .level_in(level), .comp_out(comp));
	// ============================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one transfer, request held until ready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	// polling status does not clear the flag
	task automatic wait_flag();
		int k;
		k = 0;
		do begin
			apb(1'b0, 8'h00, 32'h0);
			k++;
		end while (rd[7] !== 1'b1 && k < 150);
	endtask
	function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
		case (m)
			2'h0: return {8'h00, v[9:2]};
			2'h1: return {6'h00, v};
			2'h2: return {v, 6'h00};
			default: return {~v[9], v[8:0], 6'h00};
		endcase
	endfunction
	// ============================================================
	// tests
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b1, 8'h04, 32'hFF);
		rd_chk(8'h00, 32'h1F);
		rd_chk(8'h0C, 32'h04);
		rd_chk(8'h04, 32'h00);
		rd_chk(8'h08, 32'h00);
		rd_chk(8'h10, 32'h00);
		chk(err, 1'b1);
		apb(1'b1, 8'h0C, 32'h24);
		$display("reset test done");
		for (n = 0; n < 9; n++) begin
			apb(1'b1, 8'h00, (n < 7) ? n : n + 22);
			repeat (2) @(posedge clk);
			chk(ovr, (n < 7) ? 7'h01 << n : 7'h00);
			chk(ch_sel, (n < 7) ? n : n + 22);
		end
		level <= 10'h2C9;
		repeat (100) @(posedge clk);
		rd_chk(8'h00, 32'h1E);
		ext_run <= 1'b1;
		wait_flag();
		chk(rd, 32'h9E);
		rd_chk(8'h04, 32'h02);
		rd_chk(8'h08, 32'hC9);
		$display("channel test done");
		for (n = 0; n < 4; n++) begin
			apb(1'b1, 8'h0C, {24'h0, 3'h2, 1'b1, n[1:0], 2'h0});
			level <= 10'h2B5 ^ {n[1:0], 8'h00};
			apb(1'b1, 8'h00, 32'h03);
			wait_flag();
			chk(rd, 32'h83);
			e = fmt(n[1:0], level);
			rd_chk(8'h04, {24'h0, e[15:8]});
			rd_chk(8'h08, {24'h0, e[7:0]});
			rd_chk(8'h00, 32'h03);
		end
		$display("format test done");
		for (n = 0; n < 6; n++) begin
			// each listed code must land in range; the divide-by-16 codes share one window, faster ones time the divider
			apb(1'b1, 8'h0C, {24'h0, dv[n], 1'b1, 2'h1, 2'h0});
			apb(1'b1, 8'h00, 32'h43);
			c = 0;
			while (irq !== 1'b1 && c < 1200) begin
				@(posedge clk);
				c++;
			end
			r = dv[n][2] ? 16 : 1 << dv[n];
			chk(c >= 16 * r && c <= 17 * r + 4, 1'b1);
			apb(1'b0, 8'h08, 32'h0);
			repeat (2) @(posedge clk);
			chk(irq, 1'b0);
		end
		apb(1'b1, 8'h00, 32'hC3);
		repeat (150) @(posedge clk);
		chk(irq, 1'b0);
		rd_chk(8'h00, 32'hC3);
		apb(1'b0, 8'h08, 32'h0);
		$display("interrupt test done");
		level <= 10'h155;
		apb(1'b1, 8'h00, 32'h23);
		wait_flag();
		level <= 10'h2AA;
		repeat (150) @(posedge clk);
		rd_chk(8'h00, 32'hA3);
		rd_chk(8'h04, 32'h02);
		level <= 10'h0F0;
		repeat (150) @(posedge clk);
		rd_chk(8'h08, 32'hAA);
		repeat (150) @(posedge clk);
		rd_chk(8'h04, 32'h00);
		rd_chk(8'h08, 32'hF0);
		apb(1'b1, 8'h00, 32'h1F);
		repeat (150) @(posedge clk);
		rd_chk(8'h00, 32'h1F);
		chk(pwr_on, 1'b0);
		$display("continuous test done");
		// first result after power-up is not compared: settling
		apb(1'b1, 8'h00, 32'h03);
		repeat (20) @(posedge clk);
		stop <= 1'b1;
		repeat (10) @(posedge clk);
		stop <= 1'b0;
		repeat (40) @(posedge clk);
		rd_chk(8'h00, 32'h03);
		wait_flag();
		chk(rd, 32'h83);
		$display("stop test done");
		conclude();
	end
	// watchdog, the sequence needs well under this
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end
endmodule
`default_nettype wire
